// ===== ssha_map.svh
// Constants for the serial host access port: header layout, control bits, timing
`ifndef SSHA_MAP_SVH
`define SSHA_MAP_SVH

// ==================================================
// Header layout
`define SSHA_HDR_LONG_BYTES   4'h8
`define SSHA_HDR_SHORT_BYTES  4'h4
`define SSHA_BITS_PER_BYTE    4'h8

// ==================================================
// Control byte fields
`define SSHA_CTL_AUTOINC      7
`define SSHA_CTL_READ         6
`define SSHA_CTL_COMMON       5
`define SSHA_CTL_LENREG       4
`define SSHA_CTL_LENHI_MSB    3

// ==================================================
// Controller registers, byte addresses
`define SSHA_REG_CTRL         8'h00
`define SSHA_REG_ADDR         8'h04
`define SSHA_REG_LEN          8'h08
`define SSHA_REG_DATA         8'h0C
`define SSHA_REG_STATUS       8'h10
`define SSHA_CTRL_LONG_BIT    8
`define SSHA_CTRL_BURST_BIT   9
`define SSHA_CTRL_START_BIT   16
`define SSHA_STAT_BUSY_BIT    0
`define SSHA_STAT_TXEMPTY_BIT 1
`define SSHA_STAT_RXFULL_BIT  2

// ==================================================
// Timing
`define SSHA_SYS_PERIOD_NS    10
`define SSHA_CS_OFF_NS        400
`define SSHA_CS_OFF_CYC       ((`SSHA_CS_OFF_NS + `SSHA_SYS_PERIOD_NS - 1) / `SSHA_SYS_PERIOD_NS)
`define SSHA_SCLK_HALF_CYC    2
`define SSHA_GAP_CYC          24

`endif

// ===== ssha_pkg.sv
// Types shared by both ends of the serial host access port, plus the controller's sequencer states
package ssha_pkg;

  typedef logic [7:0]  ssha_byte_t;
  typedef logic [31:0] ssha_addr_t;
  typedef logic [23:0] ssha_len_t;

  typedef enum logic [2:0]
  {
    SSHA_H_IDLE   = 3'b000,
    SSHA_H_LOAD   = 3'b001,
    SSHA_H_GAP    = 3'b010,
    SSHA_H_SHIFT  = 3'b011,
    SSHA_H_FINISH = 3'b100
  } ssha_host_state_t;

endpackage

// ===== ssha_link_if.sv
// Serial link between the access controller and the device port
`timescale 1ns/100ps

interface ssha_link_if;
  logic slave_select_n;
  logic sclk;
  logic mosi;
  logic miso;

  modport dev
  (
    input  slave_select_n,
    input  sclk,
    input  mosi,
    output miso
  );

  modport ctl
  (
    output slave_select_n,
    output sclk,
    output mosi,
    input  miso
  );
endinterface

// ===== ssha_device.sv
// Device end: serial slave giving an external host access to the internal address space
`timescale 1ns/100ps
`include "ssha_map.svh"
// ==================================================

module ssha_device
(
  // Clock and reset of the internal bus side
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // Serial link
  ssha_link_if.dev               link,
  // Configuration from the internal processor
  input  wire logic              cfg_long_hdr,
  input  wire logic [15:0]       cfg_base_addr,
  input  wire logic [15:0]       cfg_common_base,
  input  wire ssha_pkg::ssha_len_t cfg_length,
  // Internal bus master
  output logic                   bus_req,
  output logic                   bus_write,
  output ssha_pkg::ssha_addr_t   bus_addr,
  output ssha_pkg::ssha_byte_t   bus_wdata,
  input  wire logic              bus_ack,
  input  wire ssha_pkg::ssha_byte_t bus_rdata,
  // Status
  output logic                   frame_active,
  output logic                   data_phase
);
  import ssha_pkg::*;

  // ==================================================
  // Link domain: bit counting and shifting
  // Select release clears the frame state without needing a clock edge,
  // since the host clock stands still outside frames.
  logic [2:0]  bit_cnt;
  logic [6:0]  rx_sr;
  ssha_byte_t  out_sr;
  ssha_byte_t  byte_hold;
  logic        byte_tgl;
  ssha_byte_t  rd_hold;

  always_ff @(posedge link.sclk or posedge link.slave_select_n)
  begin
    if (link.slave_select_n)
    begin
      bit_cnt <= 3'h0;
      rx_sr   <= 7'h00;
      out_sr  <= 8'h00;
    end
    else
    begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sr   <= {rx_sr[5:0], link.mosi};
      if (bit_cnt == 3'h0)
        out_sr <= {rd_hold[6:0], 1'b0};
      else
        out_sr <= {out_sr[6:0], 1'b0};
    end
  end

  // Each eighth bit hands the byte over; the holder stays put for seven more
  // link edges, which is ample for the toggle to cross.
  always_ff @(posedge link.sclk or posedge reset)
  begin
    if (reset)
    begin
      byte_tgl  <= 1'b0;
      byte_hold <= 8'h00;
    end
    else if (bit_cnt == 3'h7)
    begin
      byte_hold <= {rx_sr, link.mosi};
      byte_tgl  <= ~byte_tgl;
    end
  end

  // First bit comes straight from the prefetched byte; it has been stable
  // since the host's inter-byte gap.
  assign link.miso = (bit_cnt == 3'h0) ? rd_hold[7] : out_sr[7];

  // ==================================================
  // Crossing into the bus domain
  logic tgl_meta;
  logic tgl_sync;
  logic tgl_seen;
  logic ss_meta;
  logic ss_sync;
  logic byte_evt;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tgl_meta <= 1'b0;
      tgl_sync <= 1'b0;
      tgl_seen <= 1'b0;
      ss_meta  <= 1'b1;
      ss_sync  <= 1'b1;
    end
    else
    begin
      tgl_meta <= byte_tgl;
      tgl_sync <= tgl_meta;
      tgl_seen <= tgl_sync;
      ss_meta  <= link.slave_select_n;
      ss_sync  <= ss_meta;
    end
  end

  assign byte_evt     = tgl_sync ^ tgl_seen;
  assign frame_active = ~ss_sync;

  // ==================================================
  // Header decode and data phase
  logic [3:0]  hdr_idx;
  logic [55:0] hdr_sr;
  logic        is_read;
  logic        auto_inc;
  ssha_len_t   remain;
  ssha_addr_t  next_addr;
  ssha_byte_t  rx_byte;
  logic [3:0]  hdr_len;
  logic        hdr_last;
  ssha_addr_t  hdr_addr;
  ssha_byte_t  hdr_ctl;
  ssha_len_t   hdr_count;
  ssha_addr_t  step;

  assign rx_byte  = byte_hold;
  assign hdr_len  = cfg_long_hdr ? `SSHA_HDR_LONG_BYTES : `SSHA_HDR_SHORT_BYTES;
  assign hdr_last = (hdr_idx == hdr_len - 4'h1);
  assign step     = auto_inc ? 32'h00000001 : 32'h00000000;

  // Field extraction from the earlier header bytes plus the one now arriving
  always_comb
  begin
    if (cfg_long_hdr)
    begin
      hdr_addr  = hdr_sr[55:24];
      hdr_ctl   = hdr_sr[23:16];
      hdr_count = {hdr_sr[15:0], rx_byte};
    end
    else
    begin
      hdr_ctl = hdr_sr[7:0];
      if (hdr_ctl[`SSHA_CTL_COMMON])
        hdr_addr = {cfg_common_base, hdr_sr[23:8]};
      else
        hdr_addr = {cfg_base_addr, hdr_sr[23:8]};
      if (hdr_ctl[`SSHA_CTL_LENREG])
        hdr_count = cfg_length;
      else
        hdr_count = {12'h000, hdr_ctl[`SSHA_CTL_LENHI_MSB:0], rx_byte};
    end
  end

  // A byte event outranks the select release, so a last byte whose toggle
  // lands together with the release is still carried out.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      hdr_idx    <= 4'h0;
      hdr_sr     <= 56'h0;
      data_phase <= 1'b0;
      is_read    <= 1'b0;
      auto_inc   <= 1'b0;
      remain     <= 24'h000000;
      next_addr  <= 32'h00000000;
    end
    else if (byte_evt)
    begin
      if (!data_phase)
      begin
        hdr_sr  <= {hdr_sr[47:0], rx_byte};
        hdr_idx <= hdr_idx + 4'h1;
        if (hdr_last)
        begin
          data_phase <= 1'b1;
          is_read    <= hdr_ctl[`SSHA_CTL_READ];
          auto_inc   <= hdr_ctl[`SSHA_CTL_AUTOINC];
          remain     <= hdr_count;
          if (hdr_ctl[`SSHA_CTL_READ] && hdr_ctl[`SSHA_CTL_AUTOINC])
            next_addr <= hdr_addr + 32'h00000001;
          else
            next_addr <= hdr_addr;
        end
      end
      else if (remain != 24'h000000)
      begin
        remain <= remain - 24'h000001;
        if (!is_read || remain != 24'h000001)
          next_addr <= next_addr + step;
      end
    end
    else if (ss_sync)
    begin
      hdr_idx    <= 4'h0;
      data_phase <= 1'b0;
      remain     <= 24'h000000;
    end
  end

  // ==================================================
  // Internal bus requests
  // A read is fetched ahead so the byte is ready before the host clocks it.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      bus_req   <= 1'b0;
      bus_write <= 1'b0;
      bus_addr  <= 32'h00000000;
      bus_wdata <= 8'h00;
    end
    else if (byte_evt && !data_phase && hdr_last && hdr_ctl[`SSHA_CTL_READ]
             && hdr_count != 24'h000000)
    begin
      bus_req   <= 1'b1;
      bus_write <= 1'b0;
      bus_addr  <= hdr_addr;
    end
    else if (byte_evt && data_phase && remain != 24'h000000)
    begin
      if (!is_read)
      begin
        bus_req   <= 1'b1;
        bus_write <= 1'b1;
        bus_addr  <= next_addr;
        bus_wdata <= rx_byte;
      end
      else if (remain != 24'h000001)
      begin
        bus_req   <= 1'b1;
        bus_write <= 1'b0;
        bus_addr  <= next_addr;
      end
    end
    else if (bus_ack)
    begin
      bus_req <= 1'b0;
    end
  end

  // Read data is held for the link side; it changes only on an answer
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rd_hold <= 8'h00;
    else if (bus_req && bus_ack && !bus_write)
      rd_hold <= bus_rdata;
  end

endmodule // ssha_device

// ===== ssha_host.sv
// Controller end: host that runs header and data transfers over the serial link
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "ssha_map.svh"

module ssha_host
#(
  parameter int SCLK_HALF = `SSHA_SCLK_HALF_CYC,
  parameter int GAP       = `SSHA_GAP_CYC
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Serial link
  ssha_link_if.ctl         link
);
  import ssha_pkg::*;

  // ==================================================
  // Register access, one wait state per access
  logic        acc_done;
  logic        wr_go;
  logic        rd_go;
  ssha_byte_t  reg_ctl;
  logic        reg_long;
  logic        reg_burst;
  ssha_addr_t  reg_addr;
  ssha_len_t   reg_len;
  ssha_byte_t  tx_byte;
  ssha_byte_t  rx_byte;
  logic        tx_empty;
  logic        rx_full;
  logic        tx_take;
  logic        rx_put;
  logic        busy;
  ssha_byte_t  rx_sr;

  assign avs_waitrequest = (avs_read | avs_write) & ~acc_done;
  assign wr_go           = avs_write & acc_done;
  assign rd_go           = avs_read & acc_done;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      acc_done <= 1'b0;
    else
      acc_done <= (avs_read | avs_write) & ~acc_done;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !acc_done)
    begin
      case (avs_address)
        `SSHA_REG_CTRL:   avs_readdata <= {22'h000000, reg_burst, reg_long, reg_ctl};
        `SSHA_REG_ADDR:   avs_readdata <= reg_addr;
        `SSHA_REG_LEN:    avs_readdata <= {8'h00, reg_len};
        `SSHA_REG_DATA:   avs_readdata <= {24'h000000, rx_byte};
        `SSHA_REG_STATUS: avs_readdata <= {29'h00000000, rx_full, tx_empty, busy};
        default:          avs_readdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      reg_ctl   <= 8'h00;
      reg_long  <= 1'b0;
      reg_burst <= 1'b0;
      reg_addr  <= 32'h00000000;
      reg_len   <= 24'h000000;
      tx_byte   <= 8'h00;
    end
    else if (wr_go)
    begin
      case (avs_address)
        `SSHA_REG_CTRL:
        begin
          reg_ctl   <= avs_writedata[7:0];
          reg_long  <= avs_writedata[`SSHA_CTRL_LONG_BIT];
          reg_burst <= avs_writedata[`SSHA_CTRL_BURST_BIT];
        end
        `SSHA_REG_ADDR: reg_addr <= avs_writedata;
        `SSHA_REG_LEN:  reg_len  <= avs_writedata[23:0];
        `SSHA_REG_DATA: tx_byte  <= avs_writedata[7:0];
        default:        reg_addr <= reg_addr;
      endcase
    end
  end

  // Hardware setting a flag wins over software clearing it in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_empty <= 1'b1;
      rx_full  <= 1'b0;
      rx_byte  <= 8'h00;
    end
    else
    begin
      if (tx_take)
        tx_empty <= 1'b1;
      else if (wr_go && avs_address == `SSHA_REG_DATA)
        tx_empty <= 1'b0;
      if (rx_put)
      begin
        rx_full <= 1'b1;
        rx_byte <= rx_sr;
      end
      else if (rd_go && avs_address == `SSHA_REG_DATA)
        rx_full <= 1'b0;
    end
  end

  // ==================================================
  // Link sequencer
  ssha_host_state_t state;
  logic [3:0]  hdr_idx;
  logic        in_data;
  ssha_len_t   left;
  ssha_byte_t  tx_sr;
  ssha_byte_t  hdr_byte;
  logic [3:0]  hdr_len;
  logic [3:0]  half_cnt;
  logic [15:0] wait_cnt;
  logic        is_read;
  logic        tick;
  logic        miso_meta;
  logic        miso_sync;
  logic        start;
  logic        byte_ok;

  assign is_read  = reg_ctl[`SSHA_CTL_READ];
  assign hdr_len  = reg_long ? `SSHA_HDR_LONG_BYTES : `SSHA_HDR_SHORT_BYTES;
  assign start    = wr_go && avs_address == `SSHA_REG_CTRL && avs_writedata[`SSHA_CTRL_START_BIT];
  assign busy     = (state != SSHA_H_IDLE);
  assign tick     = (wait_cnt == 16'h0000);
  assign byte_ok  = !in_data || (is_read ? !rx_full : !tx_empty);
  assign tx_take  = (state == SSHA_H_LOAD) && in_data && !is_read && !tx_empty;
  assign rx_put   = (state == SSHA_H_SHIFT) && tick && half_cnt == 4'hF && in_data && is_read;

  // Header bytes leave most significant first
  always_comb
  begin
    hdr_byte = 8'h00;
    if (reg_long)
    begin
      case (hdr_idx)
        4'h0:    hdr_byte = reg_addr[31:24];
        4'h1:    hdr_byte = reg_addr[23:16];
        4'h2:    hdr_byte = reg_addr[15:8];
        4'h3:    hdr_byte = reg_addr[7:0];
        4'h4:    hdr_byte = {reg_ctl[7:6], 6'h00};
        4'h5:    hdr_byte = reg_len[23:16];
        4'h6:    hdr_byte = reg_len[15:8];
        default: hdr_byte = reg_len[7:0];
      endcase
    end
    else
    begin
      case (hdr_idx)
        4'h0:    hdr_byte = reg_addr[15:8];
        4'h1:    hdr_byte = reg_addr[7:0];
        4'h2:    hdr_byte = reg_ctl;
        default: hdr_byte = reg_len[7:0];
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
    end
    else
    begin
      miso_meta <= link.miso;
      miso_sync <= miso_meta;
    end
  end

  // Clock rests low between bytes, so a stall for software stops the link
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state               <= SSHA_H_IDLE;
      link.slave_select_n <= 1'b1;
      link.sclk           <= 1'b0;
      link.mosi           <= 1'b0;
      hdr_idx             <= 4'h0;
      in_data             <= 1'b0;
      left                <= 24'h000000;
      tx_sr               <= 8'h00;
      rx_sr               <= 8'h00;
      half_cnt            <= 4'h0;
      wait_cnt            <= 16'h0000;
    end
    else
    begin
      if (!tick)
        wait_cnt <= wait_cnt - 16'h0001;
      case (state)
        SSHA_H_IDLE:
          if (start)
          begin
            link.slave_select_n <= 1'b0;
            hdr_idx             <= 4'h0;
            in_data             <= 1'b0;
            state               <= SSHA_H_LOAD;
          end
        SSHA_H_LOAD:
          if (byte_ok)
          begin
            tx_sr     <= !in_data ? hdr_byte : (is_read ? 8'h00 : tx_byte);
            link.mosi <= !in_data ? hdr_byte[7] : (!is_read & tx_byte[7]);
            half_cnt  <= 4'h0;
            if (!reg_burst || (in_data && is_read))
            begin
              wait_cnt <= 16'(GAP);
              state    <= SSHA_H_GAP;
            end
            else
            begin
              wait_cnt <= 16'(SCLK_HALF - 1);
              state    <= SSHA_H_SHIFT;
            end
          end
        SSHA_H_GAP:
          if (tick)
          begin
            wait_cnt <= 16'(SCLK_HALF - 1);
            state    <= SSHA_H_SHIFT;
          end
        SSHA_H_SHIFT:
          if (tick)
          begin
            wait_cnt  <= 16'(SCLK_HALF - 1);
            half_cnt  <= half_cnt + 4'h1;
            link.sclk <= ~link.sclk;
            if (!link.sclk)
              rx_sr <= {rx_sr[6:0], miso_sync};
            else
            begin
              tx_sr     <= {tx_sr[6:0], 1'b0};
              link.mosi <= tx_sr[6];
            end
            if (half_cnt == 4'hF)
            begin
              state <= SSHA_H_LOAD;
              if (!in_data)
              begin
                hdr_idx <= hdr_idx + 4'h1;
                if (hdr_idx == hdr_len - 4'h1)
                begin
                  in_data <= 1'b1;
                  left    <= reg_len;
                  if (reg_len == 24'h000000)
                    state <= SSHA_H_FINISH;
                end
              end
              else
              begin
                left <= left - 24'h000001;
                if (left == 24'h000001)
                  state <= SSHA_H_FINISH;
              end
            end
          end
        SSHA_H_FINISH:
          if (!link.slave_select_n)
          begin
            link.slave_select_n <= 1'b1;
            wait_cnt            <= 16'(`SSHA_CS_OFF_CYC);
          end
          else if (tick)
            state <= SSHA_H_IDLE;
        default:
          state <= SSHA_H_IDLE;
      endcase
    end
  end

endmodule // ssha_host

// ===== ssha_checker.sv
// Link protocol checker for the serial host access port
`timescale 1ns/100ps
`include "ssha_map.svh"
// ==================================================
// Checker
module ssha_checker
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Serial link
  input wire logic slave_select_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso
);
  localparam int OFF_MIN = `SSHA_CS_OFF_CYC;
  logic [2:0] bit_cnt;
  logic [5:0] off_cnt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Rising clock edges within the frame, modulo one byte
  always_ff @(posedge clk_sys)
  begin
    if (reset || slave_select_n)
      bit_cnt <= 3'h0;
    else if ($rose(sclk))
      bit_cnt <= bit_cnt + 3'h1;
  end

  // Deselected time, saturating so a long idle never wraps
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      off_cnt <= 6'h3F;
    else if (!slave_select_n)
      off_cnt <= 6'h00;
    else if (off_cnt != 6'h3F)
      off_cnt <= off_cnt + 6'h01;
  end

  sequence hi_half;
    sclk [*2] ##1 !sclk;
  endsequence
  sequence lo_half;
    !sclk [*2];
  endsequence

  sclk_idle_a: assert property (slave_select_n |-> !sclk)
    else $error("serial clock active while deselected");
  clk_high_a: assert property ($rose(sclk) |-> hi_half)
    else $error("serial clock high phase wrong");
  clk_low_a: assert property ($fell(sclk) |-> lo_half)
    else $error("serial clock low phase too short");
  mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while clock high");
  miso_hold_a: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("device data moved while clock high");
  byte_bits_a: assert property ($rose(slave_select_n) |-> bit_cnt == 3'h0)
    else $error("frame ended inside a byte");
  cs_gap_a: assert property ($fell(slave_select_n) |-> off_cnt >= OFF_MIN)
    else $error("select released too briefly");
  first_edge_a: assert property ($fell(slave_select_n) |-> lo_half)
    else $error("clock rose too soon after select");
  start_clk_a: assert property ($fell(slave_select_n) |-> ##[1:100] $rose(sclk))
    else $error("no clock after select");
endmodule // ssha_checker

// ===== ssha_test.sv
// Self-checking bench joining controller and device over the serial link
`timescale 1ns/100ps
`include "ssha_map.svh"
// ==================================================
// Bench
module ssha_test;
  import ssha_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        cfg_long_hdr = 1'b0;
  logic [15:0] cfg_base_addr = 16'h4A5B;
  logic [15:0] cfg_common_base = 16'hC3D2;
  ssha_len_t   cfg_length = 24'h000003;
  logic        bus_req, bus_write, frame_active, data_phase;
  logic        bus_ack = 1'b0;
  ssha_addr_t  bus_addr;
  ssha_byte_t  bus_wdata;
  ssha_byte_t  bus_rdata = 8'h00;
  int          mismatches = 0, checks_done = 0, cycles = 0, ack_wait = 0, ack_cnt = 0;
  ssha_addr_t  log_a[$];
  logic [8:0]  log_d[$];
  logic [31:0] q;

  always #5 clk_sys = ~clk_sys;

  ssha_link_if u_ssha_link_if ();
  ssha_host u_ssha_host (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(u_ssha_link_if));
  ssha_device u_ssha_device (.clk_sys(clk_sys), .reset(reset), .link(u_ssha_link_if),
    .cfg_long_hdr(cfg_long_hdr), .cfg_base_addr(cfg_base_addr), .cfg_common_base(cfg_common_base),
    .cfg_length(cfg_length), .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
    .frame_active(frame_active), .data_phase(data_phase));
  ssha_checker u_ssha_checker (.clk_sys(clk_sys), .reset(reset),
    .slave_select_n(u_ssha_link_if.slave_select_n), .sclk(u_ssha_link_if.sclk),
    .mosi(u_ssha_link_if.mosi), .miso(u_ssha_link_if.miso));

  function automatic ssha_byte_t rd_val(input ssha_addr_t a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  // ==================================================
  // Internal memory: answers after ack_wait cycles and logs every access
  always @(posedge clk_sys)
  begin
    bus_ack <= 1'b0;
    if (bus_req === 1'b1 && !bus_ack)
    begin
      if (ack_cnt >= ack_wait)
      begin
        ack_cnt <= 0;
        bus_ack <= 1'b1;
        bus_rdata <= rd_val(bus_addr);
        log_a.push_back(bus_addr);
        log_d.push_back({bus_write, bus_wdata});
      end
      else
        ack_cnt <= ack_cnt + 1;
    end
  end

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH at %0t: timeout", $time);
      tally_and_finish();
    end
  end

  // ==================================================
  // Tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge, before the design updates
  task automatic bus_rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wait_bit(input int b, input logic v);
    do bus_rw(1'b0, `SSHA_REG_STATUS, 32'h0);
    while (q[b] !== v);
  endtask

  task automatic xfer(input logic lng, input logic brst, input logic [7:0] ctl, input ssha_addr_t adr,
                      input ssha_len_t ln, input ssha_addr_t ea, input int cnt, input int dly);
    ssha_addr_t e;
    log_a.delete();
    log_d.delete();
    ack_wait = dly;
    cfg_long_hdr <= lng;
    bus_rw(1'b1, `SSHA_REG_ADDR, adr);
    bus_rw(1'b1, `SSHA_REG_LEN, {8'h00, ln});
    if (!ctl[6] && ln != 0)
      bus_rw(1'b1, `SSHA_REG_DATA, 32'h3C);
    bus_rw(1'b1, `SSHA_REG_CTRL, {15'h0, 1'b1, 6'h0, brst, lng, ctl});
    for (int i = 0; i < ln; i++)
    begin
      e = ea + (ctl[7] ? i : 0);
      if (ctl[6])
      begin
        wait_bit(`SSHA_STAT_RXFULL_BIT, 1'b1);
        bus_rw(1'b0, `SSHA_REG_DATA, 32'h0);
        check(q[7:0], rd_val(e));
        if (i + 1 < ln)
          check(data_phase, 1'b1);
      end
      else if (i > 0)
      begin
        wait_bit(`SSHA_STAT_TXEMPTY_BIT, 1'b1);
        bus_rw(1'b1, `SSHA_REG_DATA, {24'h0, i[7:0] ^ 8'h3C});
      end
    end
    wait_bit(`SSHA_STAT_BUSY_BIT, 1'b0);
    while (frame_active !== 1'b0 || bus_req !== 1'b0)
      @(negedge clk_sys);
    check(log_a.size(), cnt);
    check(data_phase, 1'b0);
    foreach (log_a[k])
    begin
      check(log_a[k], ea + (ctl[7] ? k : 0));
      check(log_d[k][8], !ctl[6]);
      if (!ctl[6])
        check(log_d[k][7:0], k[7:0] ^ 8'h3C);
    end
  endtask

  // ==================================================
  // Sequence
  // Reset rises by a scheduled update so the asynchronously cleared link flops see the edge
  initial
  begin
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    bus_rw(1'b0, `SSHA_REG_STATUS, 32'h0);
    check(q, 32'h2);
    bus_rw(1'b1, 8'h20, 32'hFFFF_FFFF);
    bus_rw(1'b0, 8'h20, 32'h0);
    check(q, 32'h0);
    xfer(1, 0, 8'hBF, 32'h1234_56FE, 24'h2, 32'h1234_56FE, 2, 0);
    xfer(1, 1, 8'hC0, 32'h0000_10FF, 24'h3, 32'h0000_10FF, 3, 5);
    xfer(1, 0, 8'h00, 32'hCAFE_0010, 24'h0, 32'hCAFE_0010, 0, 0);
    xfer(1, 1, 8'h00, 32'h89AB_CDEF, 24'h102, 32'h89AB_CDEF, 258, 3);
    xfer(0, 0, 8'h40, 32'h0000_ABCD, 24'h2, {cfg_base_addr, 16'hABCD}, 2, 5);
    xfer(0, 1, 8'hA0, 32'h0000_1234, 24'h3, {cfg_common_base, 16'h1234}, 3, 0);
    xfer(0, 0, 8'hDF, 32'h0000_00FE, 24'h3, {cfg_base_addr, 16'h00FE}, 3, 2);
    xfer(0, 1, 8'h81, 32'h0000_0100, 24'h102, {cfg_base_addr, 16'h0100}, 258, 0);
    tally_and_finish();
  end
endmodule // ssha_test
